/* dv/tb_top.sv */
// Self-checking bench for the power budget capability registers
`timescale 1ns/100ps
`include "pbc_defs.svh"
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end

module tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_wr = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic cfg_ready;
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic ee_load = 1'b0;
    logic [7:0] ee_base = 8'h00;
    logic [1:0] ee_scale = 2'h0;
    logic [1:0] ee_pmst = 2'h0;
    logic [2:0] ee_type = 3'h0;
    logic ee_done = 1'b0;
    logic load_busy;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [7:0] e_base = 8'h04;
    logic [1:0] e_scale = 2'h0;
    logic [1:0] e_pmst = 2'h0;
    logic [2:0] e_type = 3'h7;
    logic [7:0] sel_tab [5] = '{8'h01, 8'h02, 8'h80, 8'hff, 8'h00};

    pbc_top pbc_top_inst (.mclk(mclk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ready(cfg_ready),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ee_load(ee_load), .ee_base(ee_base),
        .ee_scale(ee_scale), .ee_pmst(ee_pmst), .ee_type(ee_type), .ee_done(ee_done),
        .load_busy(load_busy));

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // Expected data word; rail and sub-state are fixed, sustained forces type zero
    function automatic logic [31:0] exp_val(input logic [7:0] s);
        if (s == 8'h00)
            return {11'h000, 3'h2, e_type, e_pmst, 3'h0, e_scale, e_base};
        if (s == 8'h01)
            return {11'h000, 3'h2, 3'h0, e_pmst, 3'h0, e_scale, e_base};
        return 32'h0;
    endfunction

    // One config access; request held until taken, answer read in the ack cycle
    task automatic acc(input logic wr, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] wd, output logic [31:0] r);
        int n;
        @(negedge mclk);
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        n = 0;
        while (cfg_ready !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        `CHK(cfg_ack, 1'b1)
        r = cfg_rdata;
        cfg_req = 1'b0;
    endtask

    // Read and compare
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        acc(1'b0, a, 4'h0, 32'h0, r);
        `CHK(r, e)
    endtask

    // Reset held 5 cycles; config outputs idle and load_busy high meanwhile
    task automatic rst();
        @(negedge mclk);
        arst_n = 1'b0;
        repeat (5) @(negedge mclk);
        `CHK(load_busy, 1'b1)
        `CHK(cfg_ready, 1'b0)
        `CHK(cfg_rdata, 32'h0)
        arst_n = 1'b1;
    endtask

    // One field word from the EEPROM side
    task automatic ld(input logic [7:0] b, input logic [1:0] s, input logic [1:0] p,
        input logic [2:0] t);
        @(negedge mclk);
        {ee_base, ee_scale, ee_pmst, ee_type} = {b, s, p, t};
        ee_load = 1'b1;
        @(negedge mclk);
        ee_load = 1'b0;
    endtask

    // End of autoload; busy must drop one cycle later
    task automatic finish_load();
        @(negedge mclk);
        `CHK(load_busy, 1'b1)
        ee_done = 1'b1;
        @(negedge mclk);
        ee_done = 1'b0;
        `CHK(load_busy, 1'b0)
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog at 4000 cycles, far beyond the fewer than one hundred cycles the tests need
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        rst();
        finish_load();
        chk_rd(`PBC_OFS_HEADER, 32'h00010004);
        chk_rd(`PBC_OFS_SELECT, 32'h0);
        chk_rd(`PBC_OFS_VALUE, 32'h000b8004);
        acc(1'b1, `PBC_OFS_HEADER, 4'hf, 32'hffffffff, rd);
        `CHK(rd, 32'h0)
        chk_rd(`PBC_OFS_HEADER, 32'h00010004);
        acc(1'b1, `PBC_OFS_VALUE, 4'hf, 32'hffffffff, rd);
        chk_rd(`PBC_OFS_VALUE, exp_val(8'h00));
        chk_rd(12'h218, 32'h0);
        // Every kind of index, upper select bits written as ones
        foreach (sel_tab[i])
        begin
            acc(1'b1, `PBC_OFS_SELECT, 4'hf, {24'hffffff, sel_tab[i]}, rd);
            chk_rd(`PBC_OFS_SELECT, {24'h0, sel_tab[i]});
            chk_rd(`PBC_OFS_VALUE, exp_val(sel_tab[i]));
        end
        // Select byte disabled: write must not land
        acc(1'b1, `PBC_OFS_SELECT, 4'he, 32'h1, rd);
        chk_rd(`PBC_OFS_SELECT, 32'h0);
        acc(1'b1, `PBC_OFS_SELECT, 4'h1, 32'h1, rd);
        // Second reset in mid-run, this time with autoloaded fields
        rst();
        {e_base, e_scale, e_pmst, e_type} = {8'h5a, 2'h3, 2'h1, 3'h5};
        ld(8'h11, 2'h1, 2'h2, 3'h1);
        ld(e_base, e_scale, e_pmst, e_type);
        finish_load();
        chk_rd(`PBC_OFS_SELECT, 32'h0);
        chk_rd(`PBC_OFS_VALUE, exp_val(8'h00));
        acc(1'b1, `PBC_OFS_SELECT, 4'h1, 32'h1, rd);
        chk_rd(`PBC_OFS_VALUE, exp_val(8'h01));
        // Late field word after the load ended is ignored
        ld(8'hee, 2'h2, 2'h3, 3'h3);
        chk_rd(`PBC_OFS_VALUE, exp_val(8'h01));
        wrap_up();
    end
endmodule

/* logic/pbc_defs.svh */
// Offsets, field positions and reset values of the power budget capability
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

`define PBC_OFS_HEADER 12'h20c
`define PBC_OFS_SELECT 12'h210
`define PBC_OFS_VALUE 12'h214

`define PBC_HDR_ID_LSB 0
`define PBC_HDR_VER_LSB 16
`define PBC_HDR_NEXT_LSB 20
`define PBC_CAP_ID 16'h0004
`define PBC_CAP_VER 4'h1
`define PBC_NEXT_PTR 12'h000

`define PBC_SEL_RST 8'h00
`define PBC_SEL_MAX 8'h00
`define PBC_SEL_SUST 8'h01

`define PBC_VAL_BASE_LSB 0
`define PBC_VAL_SCALE_LSB 8
`define PBC_VAL_SUB_LSB 10
`define PBC_VAL_PMST_LSB 13
`define PBC_VAL_TYPE_LSB 15
`define PBC_VAL_RAIL_LSB 18

`define PBC_BASE_RST 8'h04
`define PBC_SCALE_RST 2'h0
`define PBC_SUB_RST 3'h0
`define PBC_PMST_RST 2'h0
`define PBC_TYPE_RST 3'h7
`define PBC_RAIL_RST 3'h2
`define PBC_TYPE_SUST 3'h0

`endif

/* logic/pbc_pkg.sv */
// Types shared by the power budget capability modules
package pbc_pkg;

    // Access sequencer states, Gray along load -> idle -> answer
    typedef enum logic [1:0] {
        PBC_ST_LOAD = 2'h0,
        PBC_ST_IDLE = 2'h1,
        PBC_ST_ACK = 2'h3
    } pbc_state_t;

    // Loadable description of one operating condition
    typedef struct packed {
        logic [7:0] base;
        logic [1:0] scale;
        logic [2:0] sub;
        logic [1:0] pmst;
        logic [2:0] ctype;
        logic [2:0] rail;
    } pbc_fields_t;

    // State of the top module, all but the check flag ee_seen
    typedef struct packed {
        pbc_state_t st;
        logic [7:0] sel;
        pbc_fields_t fld;
        logic [31:0] rdata;
    } pbc_regs_t;

endpackage

/* logic/pbc_sel_if.sv */
// Select index and condition fields passed to the value multiplexer
`timescale 1ns/100ps
interface pbc_sel_if;
    logic clk; // Clock, used only by the checks beside the multiplexer
    logic rst_n; // Reset, active low, disables those checks
    logic [7:0] sel;
    pbc_pkg::pbc_fields_t fld;
    logic [31:0] value;

    modport src (output clk, output rst_n, output sel, output fld, input value);
    modport mux (input clk, input rst_n, input sel, input fld, output value);
endinterface

/* logic/pbc_top.sv */
// Power budgeting extended capability registers behind the config port
`timescale 1ns/100ps
`include "pbc_defs.svh"
module pbc_top (
    input wire logic mclk, // 20 MHz clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic cfg_req, // Config access request
    input wire logic cfg_wr, // 1 write, 0 read
    input wire logic [11:0] cfg_addr, // Config byte address
    input wire logic [3:0] cfg_be, // Byte enables for writes
    input wire logic [31:0] cfg_wdata, // Write data
    output logic cfg_ready, // Request can be taken
    output logic cfg_ack, // Answer strobe
    output logic [31:0] cfg_rdata, // Read data, valid with ack
    input wire logic ee_load, // EEPROM field word valid
    input wire logic [7:0] ee_base, // Loaded base power
    input wire logic [1:0] ee_scale, // Loaded scale
    input wire logic [1:0] ee_pmst, // Loaded power state
    input wire logic [2:0] ee_type, // Loaded condition type
    input wire logic ee_done, // EEPROM load finished
    output logic load_busy // Autoload still in progress
);

    pbc_pkg::pbc_regs_t r;
    pbc_pkg::pbc_regs_t next_r;
    pbc_sel_if sif ();
    logic take;
    logic [31:0] header;

    ////////////////////////////////////////////////////////////////////////
    // Word address match, low two bits are byte lanes
    function automatic logic pbc_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Fixed capability header, no storage behind it
    always_comb
    begin
        header = 32'h0000_0000;
        header[`PBC_HDR_ID_LSB +: 16] = `PBC_CAP_ID;
        header[`PBC_HDR_VER_LSB +: 4] = `PBC_CAP_VER;
        header[`PBC_HDR_NEXT_LSB +: 12] = `PBC_NEXT_PTR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data word comes from the multiplexer module
    assign sif.clk = mclk;
    assign sif.rst_n = arst_n;
    assign sif.sel = r.sel;
    assign sif.fld = r.fld;

    pbc_value_mux u_mux (
        .sif(sif.mux)
    );

    ////////////////////////////////////////////////////////////////////////
    // Handshake outputs; config is held off while the autoload runs so
    // software never reads a half-loaded budget
    assign cfg_ready = (r.st == pbc_pkg::PBC_ST_IDLE);
    assign take = cfg_req && cfg_ready;
    assign cfg_ack = (r.st == pbc_pkg::PBC_ST_ACK);
    assign cfg_rdata = r.rdata;
    assign load_busy = (r.st == pbc_pkg::PBC_ST_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // Next state: autoload, access sequencing and register updates
    always_comb
    begin
        next_r = r;
        case (r.st)
            pbc_pkg::PBC_ST_LOAD:
            begin
                if (ee_load)
                begin
                    next_r.fld.base = ee_base;
                    next_r.fld.scale = ee_scale;
                    next_r.fld.pmst = ee_pmst;
                    next_r.fld.ctype = ee_type;
                end
                if (ee_done)
                begin
                    next_r.st = pbc_pkg::PBC_ST_IDLE;
                end
            end
            pbc_pkg::PBC_ST_IDLE:
            begin
                if (take)
                begin
                    next_r.st = pbc_pkg::PBC_ST_ACK;
                    next_r.rdata = 32'h0000_0000;
                    if (cfg_wr)
                    begin
                        // Only the low select byte is writable
                        if (pbc_hit(cfg_addr, `PBC_OFS_SELECT) && cfg_be[0])
                        begin
                            next_r.sel = cfg_wdata[7:0];
                        end
                    end
                    else if (pbc_hit(cfg_addr, `PBC_OFS_HEADER))
                    begin
                        next_r.rdata = header;
                    end
                    else if (pbc_hit(cfg_addr, `PBC_OFS_SELECT))
                    begin
                        next_r.rdata = {24'h00_0000, r.sel};
                    end
                    else if (pbc_hit(cfg_addr, `PBC_OFS_VALUE))
                    begin
                        next_r.rdata = sif.value;
                    end
                end
            end
            pbc_pkg::PBC_ST_ACK:
            begin
                next_r.st = pbc_pkg::PBC_ST_IDLE;
            end
            default:
            begin
                next_r.st = pbc_pkg::PBC_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, constants only under reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r.st <= pbc_pkg::PBC_ST_LOAD;
            r.sel <= `PBC_SEL_RST;
            r.fld.base <= `PBC_BASE_RST;
            r.fld.scale <= `PBC_SCALE_RST;
            r.fld.sub <= `PBC_SUB_RST;
            r.fld.pmst <= `PBC_PMST_RST;
            r.fld.ctype <= `PBC_TYPE_RST;
            r.fld.rail <= `PBC_RAIL_RST;
            r.rdata <= 32'h0000_0000;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks; a helper flag records whether any EEPROM word arrived during the autoload
    logic ee_seen;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ee_seen <= 1'b0;
        end
        else if (ee_load && load_busy)
        begin
            ee_seen <= 1'b1;
        end
    end

    default clocking pbc_cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_read(logic [11:0] ofs);
        take && !cfg_wr && pbc_hit(cfg_addr, ofs);
    endsequence

    sequence s_write_sel;
        take && cfg_wr && pbc_hit(cfg_addr, `PBC_OFS_SELECT) && cfg_be[0];
    endsequence

    sequence s_read_dflt_max;
        s_read(`PBC_OFS_VALUE) ##0 (!ee_seen && r.sel == `PBC_SEL_MAX);
    endsequence

    AST_HDR_ID: assert property (s_read(`PBC_OFS_HEADER) |=>
        cfg_ack && cfg_rdata[15:0] == 16'h0004)
        else $error("Capability ID wrong");

    AST_HDR_VER: assert property (s_read(`PBC_OFS_HEADER) |=>
        cfg_rdata[19:16] == 4'h1)
        else $error("Capability version wrong");

    AST_HDR_NEXT: assert property (s_read(`PBC_OFS_HEADER) ##1 cfg_ack
        |-> cfg_rdata[31:20] == 12'h000)
        else $error("Next offset not zero");

    AST_SEL_WRITE: assert property (s_write_sel
        |=> cfg_ack && r.sel == $past(cfg_wdata[7:0]))
        else $error("Select not stored");

    AST_SEL_RESET: assert property ($rose(arst_n) |-> r.sel == 8'h00)
        else $error("Select reset wrong");

    AST_UNSUP: assert property (s_read(`PBC_OFS_VALUE) ##0 (r.sel > 8'h01)
        |=> cfg_rdata == 32'h0000_0000)
        else $error("Unsupported index returned data");

    AST_BASE_RST: assert property (s_read_dflt_max |=>
        cfg_rdata[7:0] == 8'h04)
        else $error("Base power default wrong");

    AST_SCALE_RST: assert property (s_read_dflt_max |=>
        cfg_rdata[9:8] == 2'h0)
        else $error("Scale default wrong");

    AST_SUB_RST: assert property (s_read(`PBC_OFS_VALUE) ##0 (r.sel < 8'h02)
        |=> cfg_rdata[12:10] == 3'h0)
        else $error("Sub-state wrong");

    AST_PMST_RST: assert property (s_read_dflt_max |=>
        cfg_rdata[14:13] == 2'h0)
        else $error("Power state default wrong");

    AST_TYPE_RST: assert property (s_read_dflt_max |=>
        cfg_rdata[17:15] == 3'h7)
        else $error("Type default wrong");

    AST_RAIL: assert property (s_read(`PBC_OFS_VALUE) ##0 (r.sel < 8'h02)
        |=> cfg_rdata[20:18] == 3'h2 && cfg_rdata[31:21] == 11'h000)
        else $error("Rail or reserved bits wrong");

    AST_EE_LOAD: assert property (load_busy && ee_load |=>
        r.fld.base == $past(ee_base) && r.fld.ctype == $past(ee_type))
        else $error("EEPROM word not loaded");

    AST_EE_FROZEN: assert property (!load_busy |=> $stable(r.fld))
        else $error("Fields changed after load");

    AST_SEL_RSVD: assert property (s_read(`PBC_OFS_SELECT) |=>
        cfg_ack && cfg_rdata[31:8] == 24'h00_0000)
        else $error("Select reserved bits nonzero");

    AST_RO_WRITE: assert property (take && cfg_wr &&
        !pbc_hit(cfg_addr, `PBC_OFS_SELECT) |=> $stable(r.sel) && $stable(r.fld))
        else $error("Read-only write took effect");

    ////////////////////////////////////////////////////////////////////////
    // Handshake and autoload sequencing; a lost answer would hang software
    sequence s_load_end;
        load_busy && ee_done;
    endsequence

    sequence s_unmapped_read;
        take && !cfg_wr && !pbc_hit(cfg_addr, `PBC_OFS_HEADER)
            && !pbc_hit(cfg_addr, `PBC_OFS_SELECT) && !pbc_hit(cfg_addr, `PBC_OFS_VALUE);
    endsequence

    AST_ACK_AFTER_TAKE: assert property (take |=> cfg_ack && !cfg_ready)
        else $error("Taken request not answered");

    AST_ACK_PULSE: assert property (cfg_ack |=> !cfg_ack && cfg_ready)
        else $error("Answer strobe longer than one cycle");

    AST_LOAD_END: assert property (s_load_end |=> !load_busy && cfg_ready)
        else $error("Autoload did not end");

    AST_LOAD_HOLD: assert property (load_busy && !ee_done |=> load_busy)
        else $error("Autoload ended early");

    AST_SEL_HOLD: assert property (!(take && cfg_wr) |=> $stable(r.sel))
        else $error("Select changed without a write");

    AST_RDATA_HOLD: assert property (!take |=> $stable(cfg_rdata))
        else $error("Read data changed without an access");

    AST_WR_RDATA: assert property (take && cfg_wr |=> cfg_rdata == 32'h0000_0000)
        else $error("Write answered with nonzero data");

    AST_UNMAPPED: assert property (s_unmapped_read |=> cfg_rdata == 32'h0000_0000)
        else $error("Unmapped read returned data");

    AST_SUST_TYPE: assert property (s_read(`PBC_OFS_VALUE) ##0
        (r.sel == `PBC_SEL_SUST) |=> cfg_rdata[17:15] == 3'h0)
        else $error("Sustained entry type wrong");

    AST_MAX_BASE: assert property (s_read(`PBC_OFS_VALUE) ##0 (r.sel == `PBC_SEL_MAX)
        |=> cfg_rdata[7:0] == $past(r.fld.base) && cfg_rdata[14:13] == $past(r.fld.pmst))
        else $error("Maximum entry does not show loaded fields");

    AST_BE_MASK: assert property (take && cfg_wr && !cfg_be[0] |=> $stable(r.sel))
        else $error("Disabled select byte was written");

endmodule

/* logic/pbc_value_mux.sv */
// Builds the power budgeting data word from the select index
`timescale 1ns/100ps
`include "pbc_defs.svh"
module pbc_value_mux (
    pbc_sel_if.mux sif // Select in, data word out
);

    ////////////////////////////////////////////////////////////////////////
    // Packs fields into their bit positions, upper bits stay zero
    function automatic logic [31:0] pbc_pack(input pbc_pkg::pbc_fields_t f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`PBC_VAL_BASE_LSB +: 8] = f.base;
        w[`PBC_VAL_SCALE_LSB +: 2] = f.scale;
        w[`PBC_VAL_SUB_LSB +: 3] = f.sub;
        w[`PBC_VAL_PMST_LSB +: 2] = f.pmst;
        w[`PBC_VAL_TYPE_LSB +: 3] = f.ctype;
        w[`PBC_VAL_RAIL_LSB +: 3] = f.rail;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sustained entry shares the loaded figures but marks its own type
    always_comb
    begin
        pbc_pkg::pbc_fields_t sust;
        sust = sif.fld;
        sust.ctype = `PBC_TYPE_SUST;
        case (sif.sel)
            `PBC_SEL_MAX: sif.value = pbc_pack(sif.fld);
            `PBC_SEL_SUST: sif.value = pbc_pack(sust);
            default: sif.value = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Unsupported indices must never leak a nonzero budget
    AST_MUX_UNSUP: assert property (@(posedge sif.clk) disable iff (!sif.rst_n)
        sif.sel > 8'h01 |-> sif.value == 32'h0000_0000)
        else $error("Unsupported index gave a nonzero word");

    // Sustained entry keeps the loaded base power and shows its own type
    AST_MUX_SUST: assert property (@(posedge sif.clk) disable iff (!sif.rst_n)
        sif.sel == `PBC_SEL_SUST |-> sif.value[17:15] == `PBC_TYPE_SUST
        && sif.value[7:0] == sif.fld.base)
        else $error("Sustained word wrong");

endmodule
